// ---- inc/actac_regs.svh ----
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 8-bit special-function register bus
// Notes:   Summary below lists the behaviour this block keeps
//
// Summary of operation
// - Conversion clock equals source over divider plus one
// - Source is system clock, low-power oscillator in burst
// - Normal track: conversion starts right after trigger
// - Delayed track: three conversion clocks before converting
// - Accumulator config bit 7 enables 12-bit resolution
// - No accumulate, no burst: result word holds latest conversion; burst sums its conversions
// - Accumulate, no burst: each result added into 16-bit word
// - Accumulate-enable bit is write-only, reads zero
// - Format codes: right shift 0-3, or left-justify
// - Burst repeat code picks 1,4,8,16,32,64 conversions
// - Burst-enable bit selects burst or single conversion
// - Burst with delayed track adds three clocks per conversion
`ifndef ACTAC_REGS_SVH
`define ACTAC_REGS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ACTAC_CFG_ADDR 8'h97
`define ACTAC_ACC_ADDR 8'hba
`define ACTAC_RLO_ADDR 8'hbd
`define ACTAC_RHI_ADDR 8'hbe

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define ACTAC_CFG_RST  8'hf8
`define ACTAC_ACC_RST  8'h00
`define ACTAC_DIV_HI   7
`define ACTAC_DIV_LO   3
`define ACTAC_8B_BIT   2
`define ACTAC_TM_BIT   1
`define ACTAC_GAIN_BIT 0
`define ACTAC_12B_BIT  7
`define ACTAC_AE_BIT   6
`define ACTAC_SJ_HI    5
`define ACTAC_SJ_LO    3
`define ACTAC_RPT_HI   2
`define ACTAC_RPT_LO   0
`define ACTAC_SJ_LEFT  3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACTAC_TRACK_TICKS 2'h3

`endif

// ---- inc/actac_pkg.sv ----
// Purpose: Types shared by the converter control block
// Assumes: Included after actac_regs.svh
// Notes:   State of each module is one packed struct
package actac_pkg;

   // ----------------------------------------------------------------
   // Register bus carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } actac_sfr_t;

   // ----------------------------------------------------------------
   // Sequencer and state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_TRACK, SEQ_WAIT} actac_seq_t;

   typedef struct packed {
      logic [7:0]  cfg;
      logic [7:0]  ac;
      logic [15:0] acc;
      actac_seq_t  seq;
      logic [1:0]  trk;
      logic [6:0]  left;
      logic        first;
      logic        conv_start;
      logic        complete;
      logic [7:0]  rdata;
   } actac_state_t;

   typedef struct packed {
      logic [1:0] sync;
      logic       lpo_d;
      logic [4:0] cnt;
      logic       tick;
   } actac_div_t;

endpackage

// ---- src/actac_clkdiv.sv ----
// Purpose: Conversion clock divider with selectable source
// Assumes: Oscillator pin is asynchronous to clk
// Notes:   Output is a one-cycle tick per conversion clock
`timescale 1ns/1ps
`include "actac_regs.svh"
module actac_clkdiv import actac_pkg::*; (
   input  wire logic       clk,        // System clock
   input  wire logic       rst_n,      // Async reset, low
   input  wire logic       lp_osc_pin, // Low-power oscillator
   input  wire logic       burst_sel,  // Burst mode active
   input  wire logic [4:0] div,        // Divider value
   output logic            conv_tick   // Conversion clock tick
);

   actac_div_t div_reg;
   actac_div_t div_next;
   logic       lpo_rise;
   logic       src_tick;

   // ----------------------------------------------------------------
   // Source selection
   // ----------------------------------------------------------------
   assign lpo_rise  = div_reg.sync[1] & ~div_reg.lpo_d;
   assign src_tick  = burst_sel ? lpo_rise : 1'b1;
   assign conv_tick = div_reg.tick;

   // Divide source ticks by div plus one
   always_comb begin
      div_next      = div_reg;
      div_next.sync = {div_reg.sync[0], lp_osc_pin};
      div_next.lpo_d = div_reg.sync[1];
      div_next.tick = 1'b0;
      if (src_tick) begin
         if (div_reg.cnt >= div) begin
            div_next.cnt  = 5'h00;
            div_next.tick = 1'b1;
         end else begin
            div_next.cnt = div_reg.cnt + 5'h01;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [5:0] gap;
   logic       chg;
   logic       moved;
   logic [4:0] div_d;
   logic       burst_d;

   // Settings differ from those of the previous cycle
   assign moved = (div_d != div) || (burst_d != burst_sel);

   // Cycles since last tick, and setting changes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap     <= 6'h00;
         chg     <= 1'b1;
         div_d   <= 5'h00;
         burst_d <= 1'b0;
      end else begin
         gap     <= conv_tick ? 6'h01 : ((gap == 6'h3f) ? gap : gap + 6'h01);
         chg     <= conv_tick ? moved : (chg | moved);
         div_d   <= div;
         burst_d <= burst_sel;
      end
   end

   a_div_period: assert property (@(posedge clk) disable iff (!rst_n)
      (conv_tick && !burst_sel && !chg && !moved && gap != 6'h00) |-> (gap == {1'b0, div} + 6'h01))
      else $error("conversion clock period wrong");

   a_lpo_source: assert property (@(posedge clk) disable iff (!rst_n)
      (conv_tick && $past(burst_sel)) |-> $past(lpo_rise))
      else $error("burst tick without oscillator edge");

   c_burst_tick: cover property (@(posedge clk) disable iff (!rst_n) conv_tick && burst_sel);

endmodule

// ---- src/actac_core.sv ----
// Purpose: Converter configuration, sequencing and result formatting
// Assumes: SAR returns right-justified result with a done pulse
// Notes:   Registers reached on the special-function register bus
`timescale 1ns/1ps
`include "actac_regs.svh"
module actac_core import actac_pkg::*; (
   input  wire logic        clk,                 // 20 MHz system clock
   input  wire logic        rst_n,               // Async reset, low
   input  wire actac_sfr_t  sfr,                 // Register bus request
   output logic [7:0]       sfr_rdata,           // Read data, next cycle
   input  wire logic        burst_mode_enable,   // Burst mode select
   input  wire logic        adc_enable,          // Converter enabled
   input  wire logic        start_of_conversion, // Trigger pulse
   input  wire logic        lp_osc_pin,          // Low-power oscillator
   input  wire logic [11:0] sar_result,          // Raw conversion result
   input  wire logic        sar_done,            // Result valid pulse
   output logic             conversion_clock,    // Conversion clock tick
   output logic             conv_start,          // Begin conversion pulse
   output logic             conversion_complete, // Sequence done pulse
   output logic             input_gain_select,   // Amplifier gain
   output logic             eight_bit_select,    // 8-bit resolution
   output logic             twelve_bit_select,   // 12-bit resolution
   output logic             delayed_track_select,// Delayed tracking
   output logic [15:0]      result_word          // Raw accumulator
);

   actac_state_t st_reg;
   actac_state_t st_next;
   logic [15:0]  sample;
   logic [15:0]  fmt_word;
   logic [4:0]   conv_clock_divider;
   logic [2:0]   result_shift_justify;
   logic [2:0]   burst_repeat_count;
   logic         accumulate_enable;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   // Keep only the bits of the active resolution
   function automatic logic [15:0] res_mask(input logic [11:0] v, input logic b12, input logic b8);
      if (b12) begin
         res_mask = {4'h0, v};
      end else if (b8) begin
         res_mask = {8'h00, v[7:0]};
      end else begin
         res_mask = {6'h00, v[9:0]};
      end
   endfunction

   // Conversions per burst
   function automatic logic [6:0] rpt_total(input logic [2:0] code);
      case (code)
         3'h1:    rpt_total = 7'h04;
         3'h2:    rpt_total = 7'h08;
         3'h3:    rpt_total = 7'h10;
         3'h4:    rpt_total = 7'h20;
         3'h5:    rpt_total = 7'h40;
         default: rpt_total = 7'h01;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   assign conv_clock_divider   = st_reg.cfg[`ACTAC_DIV_HI:`ACTAC_DIV_LO];
   assign eight_bit_select     = st_reg.cfg[`ACTAC_8B_BIT];
   assign delayed_track_select = st_reg.cfg[`ACTAC_TM_BIT];
   assign input_gain_select    = st_reg.cfg[`ACTAC_GAIN_BIT];
   assign twelve_bit_select    = st_reg.ac[`ACTAC_12B_BIT];
   assign accumulate_enable    = st_reg.ac[`ACTAC_AE_BIT];
   assign result_shift_justify = st_reg.ac[`ACTAC_SJ_HI:`ACTAC_SJ_LO];
   assign burst_repeat_count   = st_reg.ac[`ACTAC_RPT_HI:`ACTAC_RPT_LO];
   assign sample      = res_mask(sar_result, twelve_bit_select, eight_bit_select);
   assign sfr_rdata   = st_reg.rdata;
   assign conv_start  = st_reg.conv_start;
   assign conversion_complete = st_reg.complete;
   assign result_word = st_reg.acc;

   // Read formatting of the accumulator
   always_comb begin
      case (result_shift_justify)
         3'h1:    fmt_word = st_reg.acc >> 1;
         3'h2:    fmt_word = st_reg.acc >> 2;
         3'h3:    fmt_word = st_reg.acc >> 3;
         `ACTAC_SJ_LEFT: begin
            if (twelve_bit_select) begin
               fmt_word = st_reg.acc << 4;
            end else if (eight_bit_select) begin
               fmt_word = st_reg.acc << 8;
            end else begin
               fmt_word = st_reg.acc << 6;
            end
         end
         default: fmt_word = st_reg.acc;
      endcase
   end

   // ----------------------------------------------------------------
   // Conversion clock
   // ----------------------------------------------------------------
   actac_clkdiv u_div (
      .clk        (clk),
      .rst_n      (rst_n),
      .lp_osc_pin (lp_osc_pin),
      .burst_sel  (burst_mode_enable),
      .div        (conv_clock_divider),
      .conv_tick  (conversion_clock)
   );

   // ----------------------------------------------------------------
   // Next state: register access, sequencer, accumulator
   // ----------------------------------------------------------------
   always_comb begin
      st_next            = st_reg;
      st_next.conv_start = 1'b0;
      st_next.complete   = 1'b0;
      // Register reads
      if (sfr.rd) begin
         case (sfr.addr)
            `ACTAC_CFG_ADDR: st_next.rdata = st_reg.cfg;
            `ACTAC_ACC_ADDR: st_next.rdata = st_reg.ac & ~(8'h01 << `ACTAC_AE_BIT);
            `ACTAC_RHI_ADDR: st_next.rdata = fmt_word[15:8];
            `ACTAC_RLO_ADDR: st_next.rdata = fmt_word[7:0];
            default:         st_next.rdata = 8'h00;
         endcase
      end
      // Register writes
      if (sfr.wr) begin
         case (sfr.addr)
            `ACTAC_CFG_ADDR: st_next.cfg = sfr.wdata;
            `ACTAC_ACC_ADDR: st_next.ac = sfr.wdata;
            `ACTAC_RHI_ADDR: st_next.acc[15:8] = sfr.wdata;
            `ACTAC_RLO_ADDR: st_next.acc[7:0] = sfr.wdata;
            default: ;
         endcase
      end
      // Conversion sequencer
      case (st_reg.seq)
         SEQ_IDLE: begin
            if (start_of_conversion && (adc_enable || burst_mode_enable)) begin
               st_next.left  = burst_mode_enable ? rpt_total(burst_repeat_count) : 7'h01;
               st_next.first = 1'b1;
               if (delayed_track_select) begin
                  st_next.seq = SEQ_TRACK;
                  st_next.trk = 2'h0;
               end else begin
                  st_next.seq        = SEQ_WAIT;
                  st_next.conv_start = 1'b1;
               end
            end
         end
         SEQ_TRACK: begin
            if (conversion_clock) begin
               if (st_reg.trk == `ACTAC_TRACK_TICKS - 2'h1) begin
                  st_next.seq        = SEQ_WAIT;
                  st_next.conv_start = 1'b1;
               end else begin
                  st_next.trk = st_reg.trk + 2'h1;
               end
            end
         end
         SEQ_WAIT: begin
            if (sar_done) begin
               if (burst_mode_enable) begin
                  st_next.acc = st_reg.first ? sample : st_reg.acc + sample;
               end else if (accumulate_enable) begin
                  st_next.acc = st_next.acc + sample;
               end else begin
                  st_next.acc = sample;
               end
               st_next.first = 1'b0;
               st_next.left  = st_reg.left - 7'h01;
               if (st_reg.left > 7'h01) begin
                  if (delayed_track_select) begin
                     st_next.seq = SEQ_TRACK;
                     st_next.trk = 2'h0;
                  end else begin
                     st_next.conv_start = 1'b1;
                  end
               end else begin
                  st_next.seq      = SEQ_IDLE;
                  st_next.complete = 1'b1;
               end
            end
         end
         default: st_next.seq = SEQ_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg      <= '0;
         st_reg.cfg  <= `ACTAC_CFG_RST;
         st_reg.ac   <= `ACTAC_ACC_RST;
         st_reg.seq  <= SEQ_IDLE;
         st_reg.left <= 7'h01;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [6:0] starts;

   // Conversions begun in the current sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         starts <= 7'h00;
      end else if (st_reg.seq == SEQ_IDLE) begin
         starts <= conv_start ? 7'h01 : 7'h00;
      end else if (conv_start) begin
         starts <= starts + 7'h01;
      end
   end

   a_start_now: assert property (
      (st_reg.seq == SEQ_IDLE && start_of_conversion && adc_enable && !delayed_track_select)
      |=> conv_start) else $error("normal track start late");

   a_delay_three: assert property (
      (conv_start && $past(st_reg.seq) == SEQ_TRACK)
      |-> ($past(st_reg.trk) == 2'h2 && $past(conversion_clock))) else $error("delayed track length wrong");

   a_burst_track: assert property (
      (st_reg.seq == SEQ_WAIT && sar_done && st_reg.left > 7'h01 && delayed_track_select)
      |=> !conv_start ##1 (st_reg.seq == SEQ_TRACK)) else $error("burst track not inserted");

   a_twelve_load: assert property (
      (st_reg.seq == SEQ_WAIT && sar_done && !burst_mode_enable && !accumulate_enable
       && twelve_bit_select && !sfr.wr) |=> (result_word == {4'h0, $past(sar_result)}))
      else $error("12-bit result not loaded");

   a_single_load: assert property (
      (st_reg.seq == SEQ_WAIT && sar_done && !burst_mode_enable && !accumulate_enable
       && eight_bit_select && !twelve_bit_select) |=> (result_word == {8'h00, $past(sar_result[7:0])}))
      else $error("single result not loaded");

   a_accum_add: assert property (
      (st_reg.seq == SEQ_WAIT && sar_done && !burst_mode_enable && accumulate_enable && !sfr.wr)
      |=> (result_word == $past(result_word) + $past(sample))) else $error("accumulate missed");

   a_ae_reads_zero: assert property (
      (sfr.rd && sfr.addr == `ACTAC_ACC_ADDR) |=> (sfr_rdata[`ACTAC_AE_BIT] == 1'b0))
      else $error("write-only bit read back");

   a_format_shift: assert property (
      (sfr.rd && sfr.addr == `ACTAC_RLO_ADDR && result_shift_justify == 3'h2)
      |=> (sfr_rdata == $past(result_word[9:2]))) else $error("shift format wrong");

   a_burst_count: assert property (
      (conversion_complete && burst_mode_enable && $stable(burst_repeat_count))
      |-> (starts == rpt_total(burst_repeat_count))) else $error("burst count wrong");

   c_single: cover property (conversion_complete && !burst_mode_enable);
   c_burst64: cover property (conversion_complete && burst_mode_enable && starts == 7'h40);
   c_left_read: cover property (sfr.rd && result_shift_justify == `ACTAC_SJ_LEFT);

endmodule

// ---- tb/actac_core_tb.sv ----
// Purpose: Self-checking bench for the converter control block
// Assumes: Bench stands in for the SAR and the low-power oscillator
// Notes:   Inputs change on the rising edge by non-blocking assignment
`timescale 1ns/1ps
`include "actac_regs.svh"
module actac_core_tb import actac_pkg::*;;

   // ----------------------------------------------------------------
   // Signals and counters
   // ----------------------------------------------------------------
   logic        clk;
   logic        rst_n;
   actac_sfr_t  sfr;
   logic [7:0]  sfr_rdata;
   logic        burst_mode_enable;
   logic        adc_enable;
   logic        start_of_conversion;
   logic        lp_osc_pin;
   logic [11:0] sar_result;
   logic [11:0] sar_val;
   logic        sar_done;
   logic        conversion_clock;
   logic        conv_start;
   logic        conversion_complete;
   logic        input_gain_select;
   logic        eight_bit_select;
   logic        twelve_bit_select;
   logic        delayed_track_select;
   logic [15:0] result_word;
   logic [7:0]  rd_val;
   logic [15:0] word;
   logic        osc_run;
   int          err_total;
   int          n_compared;
   int          ticks;
   int          starts;
   int          sar_cnt;
   int          osc_cnt;
   int          lat;
   int          n;
   int          t;
   int          rpt_n [6] = '{1, 4, 8, 16, 32, 64};

   actac_core dut (
      .clk                 (clk),
      .rst_n               (rst_n),
      .sfr                 (sfr),
      .sfr_rdata           (sfr_rdata),
      .burst_mode_enable   (burst_mode_enable),
      .adc_enable          (adc_enable),
      .start_of_conversion (start_of_conversion),
      .lp_osc_pin          (lp_osc_pin),
      .sar_result          (sar_result),
      .sar_done            (sar_done),
      .conversion_clock    (conversion_clock),
      .conv_start          (conv_start),
      .conversion_complete (conversion_complete),
      .input_gain_select   (input_gain_select),
      .eight_bit_select    (eight_bit_select),
      .twelve_bit_select   (twelve_bit_select),
      .delayed_track_select(delayed_track_select),
      .result_word         (result_word)
   );

   // ----------------------------------------------------------------
   // Clock, SAR stand-in, oscillator and event counters
   // ----------------------------------------------------------------
   // 50 ns system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // SAR answers three cycles after each begin pulse
   always @(posedge clk) begin
      sar_done <= 1'b0;
      if (conv_start === 1'b1) begin
         sar_cnt <= 3;
      end else if (sar_cnt > 0) begin
         sar_cnt <= sar_cnt - 1;
      end
      if (sar_cnt == 1) begin
         sar_done   <= 1'b1;
         sar_result <= sar_val;
      end
   end

   // Low-power oscillator, ten clocks a period, still when stopped
   always @(posedge clk) begin
      if (osc_run) begin
         osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
         if (osc_cnt == 4) begin
            lp_osc_pin <= ~lp_osc_pin;
         end
      end
   end

   // Count conversion clock ticks and begin pulses
   always @(posedge clk) begin
      if (conversion_clock === 1'b1) begin
         ticks <= ticks + 1;
      end
      if (conv_start === 1'b1) begin
         starts <= starts + 1;
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      if (err_total == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      sfr.wr <= 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a);
      @(posedge clk);
      sfr <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      sfr.rd <= 1'b0;
      @(posedge clk);
      #1 rd_val = sfr_rdata;
   endtask

   // Formatted 16-bit result through both byte addresses
   task automatic rd_word;
      sfr_rd(`ACTAC_RHI_ADDR);
      word[15:8] = rd_val;
      sfr_rd(`ACTAC_RLO_ADDR);
      word[7:0] = rd_val;
   endtask

   // Skip the tick launched under the old setting, then count
   task automatic count_ticks(input int cyc, output int d);
      int t0;
      repeat (2) @(posedge clk);
      #1 t0 = ticks;
      repeat (cyc) @(posedge clk);
      #1 d = ticks - t0;
   endtask

   // One trigger; latency to first begin pulse and number of pulses
   task automatic run_conv(output int l, output int cnt);
      int s0;
      s0 = starts;
      l = -1;
      @(posedge clk);
      start_of_conversion <= 1'b1;
      @(posedge clk);
      start_of_conversion <= 1'b0;
      for (int c = 0; c < 3000; c++) begin
         #1;
         if (conv_start === 1'b1 && l < 0) begin
            l = c;
         end
         if (conversion_complete === 1'b1) begin
            break;
         end
         @(posedge clk);
      end
      #1;
      check({15'h0000, conversion_complete}, 16'h0001);
      cnt = starts - s0;
   endtask

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial begin
      #(20000 * 50);
      err_total++;
      print_verdict;
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      sfr = '0;
      rst_n = 1'b0;
      burst_mode_enable = 1'b0;
      adc_enable = 1'b0;
      start_of_conversion = 1'b0;
      lp_osc_pin = 1'b0;
      sar_result = 12'h000;
      sar_val = 12'h001;
      sar_done = 1'b0;
      osc_run = 1'b0;
      err_total = 0;
      n_compared = 0;
      ticks = 0;
      starts = 0;
      sar_cnt = 0;
      osc_cnt = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, unmapped read
      sfr_rd(`ACTAC_CFG_ADDR);
      check(16'(rd_val), 16'h00f8);
      sfr_rd(`ACTAC_ACC_ADDR);
      check(16'(rd_val), 16'h0000);
      sfr_rd(8'h55);
      check(16'(rd_val), 16'h0000);
      check(16'({input_gain_select, eight_bit_select, twelve_bit_select}), 16'h0000);
      // Configuration select bits
      sfr_wr(`ACTAC_CFG_ADDR, 8'h07);
      sfr_rd(`ACTAC_CFG_ADDR);
      check(16'(rd_val), 16'h0007);
      check(16'(eight_bit_select), 16'h0001);
      check(16'(input_gain_select), 16'h0001);
      check(16'(delayed_track_select), 16'h0001);
      // Write-only accumulate bit, 12-bit select
      sfr_wr(`ACTAC_ACC_ADDR, 8'hc0);
      sfr_rd(`ACTAC_ACC_ADDR);
      check(16'(rd_val), 16'h0080);
      check(16'(twelve_bit_select), 16'h0001);
      sfr_wr(`ACTAC_ACC_ADDR, 8'h00);
      sfr_rd(`ACTAC_ACC_ADDR);
      check(16'(twelve_bit_select), 16'h0000);
      // Divider from system clock: 4 and 32 clocks a tick
      sfr_wr(`ACTAC_CFG_ADDR, 8'h18);
      count_ticks(40, t);
      check(16'(t), 16'h000a);
      sfr_wr(`ACTAC_CFG_ADDR, 8'hf8);
      count_ticks(64, t);
      check(16'(t), 16'h0002);
      // Burst source is the oscillator only
      sfr_wr(`ACTAC_CFG_ADDR, 8'h00);
      @(posedge clk);
      burst_mode_enable <= 1'b1;
      count_ticks(40, t);
      check(16'(t), 16'h0000);
      osc_run <= 1'b1;
      count_ticks(30, t);
      count_ticks(100, t);
      check(16'(t), 16'h000a);
      // Repeat codes 0 to 5, unit results sum to the count
      for (int k = 0; k < 6; k++) begin
         sfr_wr(`ACTAC_ACC_ADDR, 8'(k));
         run_conv(lat, n);
         check(16'(n), 16'(rpt_n[k]));
         check(result_word, 16'(rpt_n[k]));
      end
      // Burst of four with delayed track: three oscillator ticks before each
      sfr_wr(`ACTAC_ACC_ADDR, 8'h01);
      sfr_wr(`ACTAC_CFG_ADDR, 8'h02);
      run_conv(lat, n);
      check(16'(lat >= 20 && lat <= 36), 16'h0001);
      check(16'(n), 16'h0004);
      // Single conversions, normal track
      sfr_wr(`ACTAC_ACC_ADDR, 8'h00);
      @(posedge clk);
      osc_run <= 1'b0;
      burst_mode_enable <= 1'b0;
      adc_enable <= 1'b1;
      sfr_wr(`ACTAC_CFG_ADDR, 8'h00);
      sar_val = 12'h123;
      run_conv(lat, n);
      check(16'(lat), 16'h0000);
      check(result_word, 16'h0123);
      sar_val = 12'h045;
      run_conv(lat, n);
      check(result_word, 16'h0045);
      // Resolution masks: 8-bit, 10-bit, then 12-bit
      sar_val = 12'hfab;
      sfr_wr(`ACTAC_CFG_ADDR, 8'h04);
      run_conv(lat, n);
      check(result_word, 16'h00ab);
      sfr_wr(`ACTAC_CFG_ADDR, 8'h00);
      run_conv(lat, n);
      check(result_word, 16'h03ab);
      sfr_wr(`ACTAC_ACC_ADDR, 8'h80);
      run_conv(lat, n);
      check(result_word, 16'h0fab);
      sfr_wr(`ACTAC_ACC_ADDR, 8'h00);
      // Delayed track with a tick every clock
      sfr_wr(`ACTAC_CFG_ADDR, 8'h02);
      run_conv(lat, n);
      check(16'(lat >= 3 && lat <= 5), 16'h0001);
      // Accumulate after clearing both bytes
      sfr_wr(`ACTAC_CFG_ADDR, 8'h00);
      sfr_wr(`ACTAC_ACC_ADDR, 8'h40);
      sfr_wr(`ACTAC_RHI_ADDR, 8'h00);
      sfr_wr(`ACTAC_RLO_ADDR, 8'h00);
      sar_val = 12'h100;
      run_conv(lat, n);
      sar_val = 12'h023;
      run_conv(lat, n);
      check(result_word, 16'h0123);
      // Right shifts 0..3, then left justify of 10-bit data
      for (int k = 0; k < 4; k++) begin
         sfr_wr(`ACTAC_ACC_ADDR, 8'(k << 3));
         rd_word;
         check(word, 16'h0123 >> k);
      end
      sfr_wr(`ACTAC_ACC_ADDR, 8'h20);
      rd_word;
      check(word, 16'h48c0);
      print_verdict;
   end

endmodule
